// ==== verilog/sesenc_pkg.sv ====
// Constants shared by the error-status frame encoder and its testbench.
`default_nettype none
package sesenc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] SESENC_OFS_CTRL = 8'h00;
  localparam logic [7:0] SESENC_OFS_COND = 8'h04;
  localparam logic [7:0] SESENC_OFS_STAT = 8'h08;
  localparam logic [7:0] SESENC_OFS_FCNT = 8'h0c;
  // Control register field positions.
  localparam int SESENC_CTRL_EN = 0;
  localparam int SESENC_CTRL_FMT_LO = 1;
  localparam int SESENC_CTRL_ERR_IM6 = 4;
  localparam int SESENC_CTRL_RR_IND = 5;
  localparam int SESENC_CTRL_NOFLAG = 6;
  localparam int SESENC_CTRL_SERIAL = 7;
  localparam logic [7:0] SESENC_CTRL_RST = 8'h00;
  // Condition register field positions and reset value.
  localparam int SESENC_COND_CH1_LO = 0;
  localparam int SESENC_COND_CH2_LO = 4;
  localparam logic [2:0] SESENC_COND_RST = 3'h6;
  // Status register field positions.
  localparam int SESENC_STAT_CNT_LO = 0;
  localparam int SESENC_STAT_BUSY = 8;
  localparam int SESENC_STAT_SER = 9;
  localparam int SESENC_STAT_FIFO_RDY = 10;
  // Sensor conditions.
  localparam logic [2:0] SESENC_C_OK = 3'h0;
  localparam logic [2:0] SESENC_C_PROD = 3'h1;
  localparam logic [2:0] SESENC_C_ERR = 3'h2;
  localparam logic [2:0] SESENC_C_FAULT = 3'h3;
  localparam logic [2:0] SESENC_C_INV = 3'h4;
  localparam logic [2:0] SESENC_C_RED = 3'h5;
  localparam logic [2:0] SESENC_C_INIT = 3'h6;
  // Frame formats.
  localparam logic [2:0] SESENC_F_DUAL12 = 3'h0;
  localparam logic [2:0] SESENC_F_SINGLE12 = 3'h1;
  localparam logic [2:0] SESENC_F_SINGLE16 = 3'h2;
  localparam logic [2:0] SESENC_F_SECURE = 3'h3;
  localparam logic [2:0] SESENC_F_ZERO = 3'h4;
  localparam logic [2:0] SESENC_F_DUAL14 = 3'h5;
  localparam logic [2:0] SESENC_F_DUAL16 = 3'h6;
  // Reserved indicator codes placed in a channel's data field.
  localparam logic [15:0] SESENC_IM0 = 16'h0000;
  localparam logic [15:0] SESENC_IM1 = 16'h0001;
  localparam logic [15:0] SESENC_IM5 = 16'h0005;
  localparam logic [15:0] SESENC_IM6 = 16'h0006;
  localparam logic [15:0] SESENC_IM7 = 16'h0007;
  // Measurement widths and rolling counter reset value.
  localparam int SESENC_CH1_W = 16;
  localparam int SESENC_CH2_W = 12;
  localparam logic [7:0] SESENC_CNT_RST = 8'h00;
endpackage
`default_nettype wire

// ==== verilog/sesenc_fifo.sv ====
// Small synchronous FIFO holding measurement words ahead of the frame builder.
`timescale 1ns/1ns
`default_nettype none
module sesenc_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 4
) (
  input wire logic clk, // Block clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic in_valid, // Source offers a word.
  output logic in_ready, // Space is free; registered.
  input wire logic [WIDTH-1:0] in_data, // Word offered.
  output logic out_valid, // A word is held; registered.
  input wire logic out_ready, // Drain takes the head word.
  output logic [WIDTH-1:0] out_data // Head word.
);
  localparam int AW = $clog2(DEPTH);

  // Elaboration check: the wrapping pointers only work for a power-of-two depth.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_param_check
    $error("sesenc_fifo: DEPTH must be a power of two of at least 2, WIDTH positive");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  // Handshakes only fire on flags that are already registered.
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Storage has no reset; only pointers and flags need a defined value.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers, fill count and the registered ready and valid flags.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != DEPTH[AW:0]);
      out_valid <= (cnt_d != '0);
    end
  end
endmodule // sesenc_fifo
`default_nettype wire

// ==== verilog/sesenc_top.sv ====
// Error-flag and data-nibble encoder for a single-edge nibble sensor transmitter.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [R1] Status bit 0 flags fast channel 1, bit 1 flags fast channel 2.
// [R2] Flag is 0 for valid data and initialization, 1 for any error condition.
// [R3] Data nibbles carry measurement or the reserved indicator chosen per condition.
// [R4] Dual formats place channel 2 from nibble 4, 4 or 5 per format.
// [R5] Single-channel formats use only bit 0; data in nibbles 1-3 or 1-4.
// [R6] Four-nibble single format may leave the error flag unused.
// [R7] Secure format sends rolling counter and inverted nibble 1 in nibbles 4-6; nibbles 4-6 are zero here for PROD, FAULT and INIT.
// [R8] Trailing-zero format drives nibbles 4-6 to zero outside production state.
// [R9] Reduced reliability sends measurement or indicator 7, as software selects.
// [R10] Checksum excludes the status nibble; flags are not checksum protected.
// [R11] Receiver should debounce the error flags rather than act on one.
// [R12] Restricted accuracy raises the flag and reports over the serial channel.
// [R13] Serial status may run while measurement continues on fast channels.
// [R14] Receiver prefers serial-channel information over the fast-channel indicator.
// [R15] Every don't-care flag or nibble is driven to zero.
module sesenc_top
  import sesenc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk, // 10 MHz block clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write when high.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic meas_valid, // Measurement word offered.
  output logic meas_ready, // Measurement buffer has room.
  input wire logic [SESENC_CH1_W-1:0] meas_ch1, // Channel 1 measurement value.
  input wire logic [SESENC_CH2_W-1:0] meas_ch2, // Channel 2 measurement value.
  output logic frame_valid, // Frame contents are offered.
  input wire logic frame_ready, // Nibble timer takes the frame.
  output logic [1:0] frame_flags, // Status nibble bits 1 and 0.
  output logic [23:0] frame_data, // Data nibbles, nibble 1 in bits 23:20.
  output logic ser_err_valid, // Error status pending for the serial channel.
  output logic [2:0] ser_err_code // Condition reported over the serial channel.
);
  // A buffer word carries both channels, so they always reach the same frame together.
  localparam int FW = SESENC_CH1_W + SESENC_CH2_W;

  // Elaboration check: the buffer's wrapping pointers need a power-of-two depth.
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_check
    $error("sesenc_top: FIFO_DEPTH must be a power of two of at least 2");
  end

  // One-hot slot state: idle waits for a word, send holds the frame until it is taken.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } sesenc_state_t;

  // Registered state: slot, software registers, rolling counter and frame tally.
  sesenc_state_t state_q;
  logic [7:0] ctrl_q;
  logic [2:0] cond1_q;
  logic [2:0] cond2_q;
  logic [7:0] roll_q;
  logic [15:0] fcnt_q;
  // Buffer handshake, decoded control and the combinational frame image.
  logic fifo_valid;
  logic fifo_pop;
  logic [FW-1:0] fifo_data;
  logic [2:0] fmt;
  logic en;
  logic apb_wr;
  logic apb_map;
  logic [31:0] rd_d;
  logic [15:0] v1;
  logic [15:0] v2;
  logic f1;
  logic f2;
  logic [1:0] flags_d;
  logic [23:0] data_d;
  logic si_used;
  logic [11:0] si_val;

  // Decoded control fields; both are read straight from the control register.
  assign en = ctrl_q[SESENC_CTRL_EN];
  assign fmt = ctrl_q[SESENC_CTRL_FMT_LO +: 3];

  // A channel's error flag: set for every failure kind, clear otherwise.
  // Production state could leave it free, but it is driven low so frames repeat exactly.
  function automatic logic err_flag(input logic [2:0] c);
    return (c == SESENC_C_ERR) || (c == SESENC_C_FAULT) || // R2
           (c == SESENC_C_INV) || (c == SESENC_C_RED); // R12
  endfunction

  // Field contents of one channel for its condition.
  // Code 7 is unused; it yields an all-zero field rather than stale measurement bits.
  function automatic logic [15:0] chan_val(input logic [2:0] c, input logic [15:0] m,
                                           input logic im6, input logic rr_ind);
    unique case (c)
      SESENC_C_OK: return m; // R3
      SESENC_C_PROD: return SESENC_IM1; // R3
      SESENC_C_ERR: return im6 ? SESENC_IM6 : SESENC_IM5; // R3
      SESENC_C_FAULT: return SESENC_IM6; // R3
      SESENC_C_INV: return SESENC_IM7; // R3
      SESENC_C_RED: return rr_ind ? SESENC_IM7 : m; // R9
      SESENC_C_INIT: return SESENC_IM0; // R3
      default: return 16'h0000; // R15
    endcase
  endfunction

  // Measurement buffer; its ready stalls the upstream sampler directly.
  sesenc_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(meas_valid),
    .in_ready(meas_ready),
    .in_data({meas_ch1, meas_ch2}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // A word is taken only when the frame slot is free.
  // A disabled encoder leaves words waiting, so enabling it later sends them in order.
  assign fifo_pop = (state_q == ST_IDLE) && en && fifo_valid;

  // Channel values and flags for the word at the buffer head.
  always_comb begin
    v1 = chan_val(cond1_q, fifo_data[FW-1 -: SESENC_CH1_W],
                  ctrl_q[SESENC_CTRL_ERR_IM6], ctrl_q[SESENC_CTRL_RR_IND]);
    v2 = chan_val(cond2_q, {4'h0, fifo_data[SESENC_CH2_W-1:0]},
                  ctrl_q[SESENC_CTRL_ERR_IM6], ctrl_q[SESENC_CTRL_RR_IND]);
    f1 = err_flag(cond1_q);
    f2 = err_flag(cond2_q);
  end

  // Secure information is sent only for the OK, ERR, INV and RED conditions.
  // The inverted copy follows the field after indicator selection, as nibble 1 is sent.
  always_comb begin
    si_used = (cond1_q == SESENC_C_OK) || (cond1_q == SESENC_C_ERR) || // R7
              (cond1_q == SESENC_C_INV) || (cond1_q == SESENC_C_RED); // R7
    si_val = si_used ? {roll_q, ~v1[11:8]} : 12'h000; // R7 R15
  end

  // Frame assembly per format; the status nibble stays a separate output.
  // Format code 7 is unused and sends an all-zero frame with both flags low.
  always_comb begin
    flags_d = 2'b00;
    data_d = 24'h000000;
    unique case (fmt)
      SESENC_F_DUAL12: begin
        flags_d = {f2, f1}; // R1
        data_d = {v1[11:0], v2[3:0], v2[7:4], v2[11:8]}; // R4
      end
      SESENC_F_DUAL14: begin
        flags_d = {f2, f1}; // R1
        data_d = {v1[13:0], v2[1:0], v2[5:2], v2[9:6]}; // R4
      end
      SESENC_F_DUAL16: begin
        flags_d = {f2, f1}; // R1
        data_d = {v1[15:0], v2[3:0], v2[7:4]}; // R4
      end
      SESENC_F_SINGLE12: begin
        flags_d = {1'b0, f1}; // R5 R15
        data_d = {v1[11:0], 12'h000}; // R5 R15
      end
      SESENC_F_SINGLE16: begin
        flags_d = {1'b0, f1 && !ctrl_q[SESENC_CTRL_NOFLAG]}; // R5 R6
        data_d = {v1[15:0], 8'h00}; // R5
      end
      SESENC_F_SECURE: begin
        flags_d = {1'b0, f1}; // R5
        data_d = {v1[11:0], si_val}; // R7
      end
      SESENC_F_ZERO: begin
        flags_d = {1'b0, f1}; // R5
        data_d = {v1[11:0], 12'h000}; // R8 R15
      end
      default: begin
        flags_d = 2'b00; // R15
        data_d = 24'h000000;
      end
    endcase
  end

  // Frame slot: load on a pop, hold until the nibble timer accepts it.
  // Holding the whole frame keeps flags and nibbles of one word together on a stall.
  // The checksum is formed downstream over frame_data only. R10
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      frame_valid <= 1'b0;
      frame_flags <= 2'b00;
      frame_data <= 24'h000000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (fifo_pop) begin
            frame_flags <= flags_d;
            frame_data <= data_d;
            frame_valid <= 1'b1;
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (frame_ready) begin
            frame_valid <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          frame_valid <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Rolling counter steps once per secure frame handed over, and a frame tally.
  // Both wrap silently; the receiver only checks that the rolling counter moves on.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      roll_q <= SESENC_CNT_RST;
      fcnt_q <= 16'h0000;
    end else if (state_q == ST_SEND && frame_ready) begin
      fcnt_q <= fcnt_q + 16'h0001;
      if (fmt == SESENC_F_SECURE) begin
        roll_q <= roll_q + 8'h01; // R7
      end
    end
  end

  // Serial-channel error status runs beside the fast channels, channel 1 first.
  // Limitation: one code at a time, so a channel 2 fault waits until channel 1 is clean.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ser_err_valid <= 1'b0;
      ser_err_code <= SESENC_C_OK;
    end else if (ctrl_q[SESENC_CTRL_SERIAL] && en && err_flag(cond1_q)) begin
      ser_err_valid <= 1'b1; // R12 R13
      ser_err_code <= cond1_q;
    end else if (ctrl_q[SESENC_CTRL_SERIAL] && en && err_flag(cond2_q) &&
                 fmt inside {SESENC_F_DUAL12, SESENC_F_DUAL14, SESENC_F_DUAL16}) begin
      ser_err_valid <= 1'b1; // R12 R13
      ser_err_code <= cond2_q;
    end else begin
      ser_err_valid <= 1'b0;
      ser_err_code <= SESENC_C_OK;
    end
  end

  // APB decode; the slave answers in the first access cycle.
  assign apb_map = (paddr == SESENC_OFS_CTRL) || (paddr == SESENC_OFS_COND) ||
                   (paddr == SESENC_OFS_STAT) || (paddr == SESENC_OFS_FCNT);
  assign apb_wr = psel && penable && pready && pwrite;

  // Read multiplexer; unused bits read as zero so software need not mask them.
  always_comb begin
    rd_d = 32'h00000000;
    unique case (paddr)
      SESENC_OFS_CTRL: rd_d = {24'h000000, ctrl_q};
      SESENC_OFS_COND: rd_d = {25'h0000000, cond2_q, 1'b0, cond1_q};
      SESENC_OFS_STAT: rd_d = {21'h000000, meas_ready, ser_err_valid,
                               frame_valid, roll_q};
      SESENC_OFS_FCNT: rd_d = {16'h0000, fcnt_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  // Ready, error and read data are registered during the setup cycle.
  // Registering them costs no wait state, as the access cycle always follows setup.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !apb_map;
      prdata <= (psel && !penable && !pwrite) ? rd_d : 32'h00000000;
    end
  end

  // Software-written control and per-channel condition registers.
  // An unmapped write falls through both offset compares and changes nothing.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= SESENC_CTRL_RST;
      cond1_q <= SESENC_COND_RST;
      cond2_q <= SESENC_COND_RST;
    end else if (apb_wr && paddr == SESENC_OFS_CTRL) begin
      ctrl_q <= pwdata[7:0];
    end else if (apb_wr && paddr == SESENC_OFS_COND) begin
      cond1_q <= pwdata[SESENC_COND_CH1_LO +: 3];
      cond2_q <= pwdata[SESENC_COND_CH2_LO +: 3];
    end
  end
endmodule // sesenc_top
`default_nettype wire

// ==== testbench/sesenc_top_checker.sv ====
// Concurrent checks on the frame encoder's ports.
`timescale 1ns/1ns
`default_nettype none
module sesenc_top_checker
  import sesenc_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB data.
  input wire logic frame_valid, // Frame offered.
  input wire logic frame_ready, // Frame taken.
  input wire logic [1:0] frame_flags, // Status bits.
  input wire logic [23:0] frame_data, // Data nibbles.
  input wire logic ser_err_valid, // Serial status.
  input wire logic [2:0] ser_err_code // Serial code.
);
  logic [7:0] ctl_q;
  logic [6:0] cnd_q;
  logic [2:0] fm;
  logic [2:0] c1;
  assign fm = ctl_q[3:1];
  assign c1 = cnd_q[2:0];
  // Shadow of control and condition, so frame content can be judged per format.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_q <= 8'h00;
      cnd_q <= 7'h66;
    end else if (psel && penable && pwrite) begin
      if (paddr == SESENC_OFS_CTRL) ctl_q <= pwdata[7:0];
      if (paddr == SESENC_OFS_COND) cnd_q <= pwdata[6:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_ch1_flag_set: assert property (frame_valid && c1 inside {[2:5]} && fm != 3'h7 &&
    !(fm == 3'h2 && ctl_q[6]) |-> frame_flags[0]) else $error("channel 1 flag low");
  chk_ch2_flag_set: assert property (frame_valid && fm inside {0, 5, 6} &&
    cnd_q[6:4] inside {[2:5]} |-> frame_flags[1]) else $error("channel 2 flag low");
  chk_flag_clear: assert property (frame_valid && (c1 == 3'h0 || c1 == 3'h6)
    |-> !frame_flags[0]) else $error("channel 1 flag high");
  chk_single_bit1: assert property (frame_valid && fm inside {[1:4]} |-> !frame_flags[1])
    else $error("bit 1 set in single format");
  chk_init_zero: assert property (frame_valid && c1 == 3'h6 && fm inside {1, 2, 4}
    |-> frame_data == 24'h0) else $error("init frame not zero");
  chk_secure_inv: assert property (frame_valid && fm == 3'h3 && c1 inside {0, 2, 4, 5}
    |-> frame_data[3:0] == ~frame_data[23:20]) else $error("secure copy wrong");
  chk_zero_tail: assert property (frame_valid && fm == 3'h4 && c1 != 3'h1
    |-> frame_data[11:0] == 12'h0) else $error("trailing nibbles not zero");
  chk_frame_hold: assert property (frame_valid && !frame_ready |=> frame_valid &&
    $stable(frame_data) && $stable(frame_flags)) else $error("frame changed while held");
  chk_ser_report: assert property (ctl_q[7] && ctl_q[0] && c1 inside {[2:5]}
    |=> ser_err_valid && ser_err_code == $past(c1)) else $error("serial status missing");
endmodule // sesenc_top_checker
bind sesenc_top sesenc_top_checker u_chk (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_flags(frame_flags),
  .frame_data(frame_data), .ser_err_valid(ser_err_valid), .ser_err_code(ser_err_code));
`default_nettype wire

// ==== testbench/sesenc_ecu.sv ====
// Receiver model on the far side of the frame stream.
`timescale 1ns/1ns
`default_nettype none
module sesenc_ecu (
  input wire logic clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic frame_valid, // Frame offered.
  input wire logic [1:0] frame_flags, // Status bits.
  input wire logic slow, // Stall when high.
  output logic frame_ready, // Frame taken.
  output logic err_seen, // Debounced flag.
  input wire logic ser_err_valid, // Serial status present.
  input wire logic [2:0] ser_err_code, // Serial status code.
  output logic [2:0] err_code // Condition as the receiver believes it.
);
  logic [1:0] st_q;
  logic [1:0] hit_q;
  assign err_seen = hit_q[1];
  // Take every frame, or one cycle in four so the encoder must hold its frame.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= 2'h0;
      frame_ready <= 1'b0;
    end else begin
      st_q <= st_q + 2'h1;
      frame_ready <= !slow || st_q == 2'h3;
    end
  end
  // The flags carry no checksum, so one flagged frame alone is not believed.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) hit_q <= 2'h0;
    else if (frame_valid && frame_ready) hit_q <= |frame_flags ? {|hit_q, 1'b1} : 2'h0;
  end
  // Serial-channel status outranks the bare flag, which only says that something is wrong.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) err_code <= 3'h0;
    else if (ser_err_valid) err_code <= ser_err_code;
    else if (frame_valid && frame_ready) err_code <= {2'h0, |frame_flags};
  end
endmodule // sesenc_ecu
`default_nettype wire

// ==== testbench/sesenc_top_bench.sv ====
// Self-checking bench for the error-status frame encoder.
`timescale 1ns/1ns
`default_nettype none
module sesenc_top_bench;
  import sesenc_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, meas_valid = 0;
  logic [7:0] paddr = 8'h00, ctl = 8'h00, roll = 8'h00;
  logic [31:0] pwdata = 0, prdata, rd, seed = 32'h1755;
  logic pready, pslverr, meas_ready, frame_valid, frame_ready, ser_err_valid, er, sx, err_seen;
  logic [15:0] meas_ch1 = 0;
  logic [11:0] meas_ch2 = 0;
  logic [1:0] frame_flags, hp = 2'h0;
  logic [23:0] frame_data;
  logic [2:0] ser_err_code, f, c1, c2, sc, err_code;
  logic [25:0] q[$];
  int n_fail = 0, cmp_count = 0, n, nfr = 0;
  sesenc_top uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid(meas_valid), .meas_ready(meas_ready), .meas_ch1(meas_ch1),
    .meas_ch2(meas_ch2), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame_flags(frame_flags), .frame_data(frame_data), .ser_err_valid(ser_err_valid),
    .ser_err_code(ser_err_code));
  sesenc_ecu ecu (.clk(clk), .nrst(nrst), .frame_valid(frame_valid),
    .frame_flags(frame_flags), .slow(slow), .frame_ready(frame_ready), .err_seen(err_seen),
    .ser_err_valid(ser_err_valid), .ser_err_code(ser_err_code), .err_code(err_code));
  always #50 clk = ~clk;
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Field of one channel for a condition: value or indicator code.
  function logic [15:0] fld(input logic [2:0] c, input logic [15:0] m);
    case (c)
      3'h0: fld = m;
      3'h1: fld = 16'h1;
      3'h2: fld = ctl[4] ? 16'h6 : 16'h5;
      3'h3: fld = 16'h6;
      3'h4: fld = 16'h7;
      3'h5: fld = ctl[5] ? 16'h7 : m;
      default: fld = 16'h0;
    endcase
  endfunction
  function logic [25:0] exp_f(input logic [15:0] m1, input logic [11:0] m2);
    logic [15:0] a;
    logic [15:0] b;
    logic e1;
    logic e2;
    a = fld(c1, m1);
    b = fld(c2, {4'h0, m2});
    e1 = c1 inside {[2:5]} && !(f == 3'h2 && ctl[6]);
    e2 = f inside {0, 5, 6} && c2 inside {[2:5]};
    case (f)
      3'h0: exp_f = {e2, e1, a[11:0], b[3:0], b[7:4], b[11:8]};
      3'h2: exp_f = {1'b0, e1, a, 8'h0};
      3'h3: exp_f = {1'b0, e1, a[11:0], c1 inside {0, 2, 4, 5} ? {roll, ~a[11:8]} : 12'h0};
      3'h5: exp_f = {e2, e1, a[13:0], b[1:0], b[5:2], b[9:6]};
      3'h6: exp_f = {e2, e1, a, b[3:0], b[7:4]};
      3'h7: exp_f = 26'h0;
      default: exp_f = {1'b0, e1, a[11:0], 12'h0};
    endcase
  endfunction
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do @(posedge clk); while (!pready && ++n < 50);
    if (n == 50) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task push(input logic [15:0] a, input logic [11:0] b);
    logic [25:0] e;
    @(posedge clk);
    meas_valid <= 1;
    meas_ch1 <= a;
    meas_ch2 <= b;
    n = 0;
    do @(posedge clk); while (!meas_ready && ++n < 99);
    if (n == 99) n_fail++;
    meas_valid <= 0;
    e = exp_f(a, b);
    q.push_back(e);
    hp = {hp[0], |e[25:24]};
    if (f == 3'h3) roll++;
    nfr++;
  endtask
  task drain;
    n = 0;
    while (q.size() != 0 && n++ < 500) @(posedge clk);
    if (q.size() != 0) n_fail++;
    repeat (2) @(posedge clk);
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Every accepted frame is matched against the oldest expectation.
  always @(posedge clk) begin
    if (frame_valid === 1'b1 && frame_ready === 1'b1) begin
      if (q.size() == 0) chk("spare frame", 0, 1);
      else chk("frame", {6'h0, q.pop_front()}, {6'h0, frame_flags, frame_data});
    end
  end
  // A hang counts as a mismatch and ends the run the usual way.
  initial begin
    #5000000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    apb(0, SESENC_OFS_CTRL, 0);
    chk("ctrl reset", 0, rd);
    apb(0, SESENC_OFS_COND, 0);
    chk("cond reset", 32'h66, rd);
    apb(0, 8'h10, 0);
    chk("unmapped", 1, {rd[30:0], er});
    $display("test registers done");
    // Every condition in each of the formats 0 to 7, options drawn at random.
    for (int i = 0; i < 56; i++) begin
      seed = lfsr(seed);
      f = 3'(i / 7);
      c1 = 3'(i % 7);
      c2 = seed[10:8];
      ctl = {seed[7:4], f, 1'b1};
      apb(1, SESENC_OFS_COND, {25'h0, c2, 1'b0, c1});
      apb(1, SESENC_OFS_CTRL, {24'h0, ctl});
      repeat (2) @(posedge clk);
      sx = ctl[7] && (c1 inside {[2:5]} || (f inside {0, 5, 6} && c2 inside {[2:5]}));
      sc = sx ? (c1 inside {[2:5]} ? c1 : c2) : 3'h0;
      chk("serial", {sx, sc}, {ser_err_valid, ser_err_code});
      push(seed[31:16], seed[23:12]);
      drain;
      chk("debounce", hp[1] & hp[0], err_seen);
      chk("priority", sx ? sc : {2'h0, hp[0]}, err_code);
    end
    $display("test conditions done");
    // Fill the buffer while disabled, then drain it against a stalling receiver.
    f = 3'h1;
    c1 = 3'h0;
    ctl = 8'h02;
    apb(1, SESENC_OFS_COND, 0);
    apb(1, SESENC_OFS_CTRL, 2);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      push({4'h0, seed[11:0]}, seed[23:12]);
    end
    @(posedge clk);
    meas_valid <= 1;
    repeat (3) @(posedge clk);
    chk("buffer full", 0, meas_ready);
    meas_valid <= 0;
    slow <= 1;
    apb(1, SESENC_OFS_CTRL, 3);
    drain;
    $display("test buffer done");
    apb(0, SESENC_OFS_STAT, 0);
    chk("roll", roll, rd[7:0]);
    apb(0, SESENC_OFS_FCNT, 0);
    chk("frames", nfr, rd);
    chk("left over", 0, q.size());
    finish_test;
  end
endmodule // sesenc_top_bench
`default_nettype wire
